// *** verilog/adc_params.svh ***
// Shared word widths, field positions, reset values and timing counts of the converter link
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
// Result word layout
`define ADC_WORD_BITS   24
`define ADC_DATA_BITS   22
`define ADC_OVH_POS     23
`define ADC_OVL_POS     22
`define ADC_CNT_BITS    5
// Clock rates in hertz
`define ADC_SYS_HZ      100000000
`define ADC_OSC_HZ      102400
`define ADC_SCK_MAX_HZ  5000000
// Conversion length and warm-up in oscillator periods
`define ADC_CONV_OSC    8192
`define ADC_WARM_OSC    144
// Times in nanoseconds
`define ADC_SHDN_NS     10000
`define ADC_CS_GAP_NS   90
// Derived cycle counts
`define ADC_OSC_DIV     (`ADC_SYS_HZ / `ADC_OSC_HZ)
`define ADC_SHDN_CYC    (`ADC_SHDN_NS * (`ADC_SYS_HZ / 1000000) / 1000)
`define ADC_SCK_HALF    ((`ADC_SYS_HZ + 2 * `ADC_SCK_MAX_HZ - 1) / (2 * `ADC_SCK_MAX_HZ))
`define ADC_GAP_CYC     ((`ADC_CS_GAP_NS * (`ADC_SYS_HZ / 1000000) + 999) / 1000)
// Reset levels of the sampled pins
`define ADC_CS_RST      1'b1
`define ADC_SCK_RST     1'b0
`endif

// *** verilog/adc_pkg.sv ***
// Types shared by both ends of the converter link
package adc_pkg;
	`include "adc_params.svh"

	typedef enum logic [1:0] {
		ADC_D_SHDN = 2'b00,
		ADC_D_IDLE = 2'b01,
		ADC_D_CONV = 2'b10
	} adc_dev_e;

	typedef enum logic [1:0] {
		ADC_H_IDLE = 2'b00,
		ADC_H_WAIT = 2'b01,
		ADC_H_CLK  = 2'b10,
		ADC_H_GAP  = 2'b11
	} adc_host_e;

	typedef logic [`ADC_WORD_BITS-1:0] adc_word_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} adc_sync_s;

	typedef struct packed {
		adc_dev_e               st;
		logic [15:0]            osc_cnt;
		logic [15:0]            conv_cnt;
		logic [15:0]            shdn_cnt;
		logic                   warm;
		logic                   first;
		logic                   pend;
		logic                   shift_en;
		logic [`ADC_CNT_BITS-1:0] bits;
		adc_word_t              sr;
		logic                   sdo;
		logic                   oe;
		logic                   done;
		logic                   shutdown;
	} adc_dev_s;

	typedef struct packed {
		adc_host_e              st;
		logic [7:0]             div;
		logic                   ph;
		logic                   armed;
		logic                   sck;
		logic                   cs_n;
		logic [`ADC_CNT_BITS-1:0] bits;
		adc_word_t              sh;
		adc_word_t              result;
		logic                   valid;
	} adc_host_s;
endpackage

// *** verilog/adc_link_if.sv ***
// Three-wire serial link between the converter and its host
`timescale 1ns/1ns
interface adc_link_if;
	logic cs_n;
	logic sck;
	logic data_ready_out;
	logic data_ready_oe;
	// Line floats high through a pull-up while the converter is off the line
	wire  sdo_line = data_ready_oe ? data_ready_out : 1'b1;

	modport dev (input cs_n, input sck, output data_ready_out, output data_ready_oe);
	modport host (output cs_n, output sck, input sdo_line);
endinterface

// *** verilog/adc_sync_edge.sv ***
// Two-stage synchroniser with edge detection behind the second stage
`timescale 1ns/1ns
module adc_sync_edge #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Asynchronous input and synchronised results
	input  wire logic din,
	output logic      lvl,
	output logic      rise,
	output logic      fall
);
	import adc_pkg::*;

	adc_sync_s s_ff;
	adc_sync_s nxt_s;

	// Shift chain; only s2 and s3 feed logic
	always_comb
	begin
		nxt_s    = s_ff;
		nxt_s.s1 = din;
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			s_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL};
		else
			s_ff <= nxt_s;
	end

	assign lvl  = s_ff.s2;
	assign rise = s_ff.s2 & ~s_ff.s3;
	assign fall = ~s_ff.s2 & s_ff.s3;
endmodule

// *** verilog/adc_dev_end.sv ***
// Converter end: conversion sequencer and serial result readout
`timescale 1ns/1ns
`include "adc_params.svh"
// Contract
// - Works with host modes 0,0 and 1,1
// - Next output bit on each falling clock
// - Link inputs captured on rising clock only
// - Host may idle clock high or low
// - Ready drives line low while selected
// - Ready then 24 bits, one per fall
// - Clock ignored while select is high
// - Select falling edge starts a conversion; with a result pending it starts that readout instead
// - Select raised early gives one conversion
// - Select held low converts back to back
// - Select tied low converts from power-up
// - Output released while select is high
// - Shuts down alone when not converting
// - Conversion state cleared between conversions
// - Calibration inside conversion, no extra time
// - Every conversion gives a settled result; a later conversion of a continuous run cut short by select rising gives none
// - Host clock no faster than 5 MHz
// - Data bits are two's complement
// - First conversion after shutdown adds 144 periods
// - Timing from own oscillator, not clock edges
// - Two bits flag positive and negative overrange
module adc_dev_end #(
	parameter int CONV_OSC = `ADC_CONV_OSC,
	parameter int OSC_DIV  = `ADC_OSC_DIV,
	parameter int SHDN_CYC = `ADC_SHDN_CYC
) (
	// Clock and reset
	input  wire logic   sys_clk,
	input  wire logic   rst,
	// Serial link
	adc_link_if.dev     link,
	// Sampled analog value, full scale is plus or minus 2**21
	input  wire logic signed [`ADC_WORD_BITS-1:0] sample_in,
	// Status
	output logic        conv_done,
	output logic        in_shutdown,
	output logic        converting
);
	import adc_pkg::*;

	adc_dev_s s_ff;
	adc_dev_s nxt_s;
	logic     cs_lvl;
	logic     cs_rise;
	logic     cs_fall;
	logic     sck_rise;
	logic     sck_fall;
	logic     osc_tick;
	logic     conv_end;

	// ************************************************
	// Pin synchronisers
	// ************************************************

	// Select resets high so a select tied low shows a fall after reset
	adc_sync_edge #(.RST_VAL(`ADC_CS_RST)) u_cs_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     (link.cs_n),
		.lvl     (cs_lvl),
		.rise    (cs_rise),
		.fall    (cs_fall)
	);

	adc_sync_edge #(.RST_VAL(`ADC_SCK_RST)) u_sck_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     (link.sck),
		.lvl     (),
		.rise    (sck_rise),
		.fall    (sck_fall)
	);

	// ************************************************
	// Result encoding
	// ************************************************

	// Overrange flags ahead of the 22 data bits; value clamps nowhere, flags tell
	function automatic adc_word_t encode(input logic signed [`ADC_WORD_BITS-1:0] v);
		logic overrange_high_bit;
		logic overrange_low_bit;
		overrange_high_bit = (v > $signed(24'h1fffff));
		overrange_low_bit = (v < $signed(24'he00000));
		encode = {overrange_high_bit, overrange_low_bit, v[`ADC_DATA_BITS-1:0]};
	endfunction

	// ************************************************
	// Oscillator and sequencer
	// ************************************************

	// Oscillator runs only while converting, held in reset otherwise
	assign osc_tick = (s_ff.st == ADC_D_CONV) && (s_ff.osc_cnt == 16'(OSC_DIV - 1));
	// Calibration is part of the conversion length, so no extra periods for it
	assign conv_end = osc_tick &&
		(s_ff.conv_cnt == 16'(CONV_OSC - 1 + (s_ff.warm ? `ADC_WARM_OSC : 0)));

	always_comb
	begin
		nxt_s      = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.oe   = ~cs_lvl;
		// Oscillator divider and period count
		if (s_ff.st == ADC_D_CONV)
		begin
			nxt_s.osc_cnt = osc_tick ? 16'h0000 : s_ff.osc_cnt + 16'h0001;
			if (osc_tick)
				nxt_s.conv_cnt = s_ff.conv_cnt + 16'h0001;
		end
		else
		begin
			nxt_s.osc_cnt = 16'h0000;
		end
		// Completion: fresh settled word, counters flushed
		if (conv_end)
		begin
			nxt_s.sr       = encode(sample_in);
			nxt_s.conv_cnt = 16'h0000;
			nxt_s.done     = 1'b1;
			nxt_s.warm     = 1'b0;
			if (!cs_lvl)
			begin
				nxt_s.sdo      = 1'b0;
				nxt_s.shift_en = 1'b1;
				nxt_s.bits     = '0;
				nxt_s.first    = 1'b0;
			end
			else
			begin
				nxt_s.pend = 1'b1;
				nxt_s.st   = ADC_D_IDLE;
			end
		end
		// Serial shifter, active only while selected
		if (s_ff.shift_en && !cs_lvl)
		begin
			// Only falls move data, so the idle level never matters
			if (sck_fall && s_ff.bits != 5'(`ADC_WORD_BITS))
			begin
				nxt_s.sdo  = s_ff.sr[`ADC_WORD_BITS-1];
				nxt_s.sr   = {s_ff.sr[`ADC_WORD_BITS-2:0], 1'b0};
				nxt_s.bits = s_ff.bits + 5'h01;
			end
			// Word ends on the rising edge that samples the last bit
			if (sck_rise && s_ff.bits == 5'(`ADC_WORD_BITS))
			begin
				nxt_s.sdo      = 1'b1;
				nxt_s.shift_en = 1'b0;
			end
		end
		// Select edges win over completion in the same cycle
		if (cs_fall)
		begin
			nxt_s.shdn_cnt = 16'h0000;
			if (s_ff.pend)
			begin
				nxt_s.pend     = 1'b0;
				nxt_s.sdo      = 1'b0;
				nxt_s.shift_en = 1'b1;
				nxt_s.bits     = '0;
			end
			else
			begin
				nxt_s.st       = ADC_D_CONV;
				nxt_s.conv_cnt = 16'h0000;
				nxt_s.osc_cnt  = 16'h0000;
				nxt_s.first    = 1'b1;
				nxt_s.sdo      = 1'b1;
				nxt_s.shift_en = 1'b0;
			end
		end
		if (cs_rise)
		begin
			nxt_s.shift_en = 1'b0;
			nxt_s.sdo      = 1'b1;
			nxt_s.shdn_cnt = 16'h0000;
			// A later conversion of a continuous run is dropped
			if (s_ff.st == ADC_D_CONV && !s_ff.first)
			begin
				nxt_s.st       = ADC_D_IDLE;
				nxt_s.conv_cnt = 16'h0000;
			end
		end
		// Idle falls to shutdown on its own
		case (s_ff.st)
			ADC_D_IDLE:
			begin
				if (!cs_fall)
					nxt_s.shdn_cnt = s_ff.shdn_cnt + 16'h0001;
				if (!cs_fall && s_ff.shdn_cnt == 16'(SHDN_CYC - 1))
				begin
					nxt_s.st   = ADC_D_SHDN;
					nxt_s.warm = 1'b1;
				end
			end
			ADC_D_SHDN: nxt_s.shdn_cnt = 16'h0000;
			ADC_D_CONV: nxt_s.shdn_cnt = 16'h0000;
			default:    nxt_s.st = ADC_D_SHDN;
		endcase
		nxt_s.shutdown = (nxt_s.st == ADC_D_SHDN);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_ff          <= '0;
			s_ff.st       <= ADC_D_SHDN;
			s_ff.warm     <= 1'b1;
			s_ff.sdo      <= 1'b1;
			s_ff.shutdown <= 1'b1;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************

	assign link.data_ready_out = s_ff.sdo;
	assign link.data_ready_oe  = s_ff.oe;
	assign conv_done           = s_ff.done;
	assign in_shutdown         = s_ff.shutdown;
	assign converting          = (s_ff.st == ADC_D_CONV);
endmodule

// *** verilog/adc_host_end.sv ***
// Host end: selects the converter, waits for ready and reads the result word
`timescale 1ns/1ns
`include "adc_params.svh"
module adc_host_end #(
	parameter logic CPOL     = 1'b0,
	parameter int   SCK_HALF = `ADC_SCK_HALF,
	parameter int   GAP_CYC  = `ADC_GAP_CYC
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Serial link
	adc_link_if.host  link,
	// User requests
	input  wire logic start,
	input  wire logic continuous,
	// User results
	output adc_pkg::adc_word_t result,
	output logic      result_valid,
	output logic      busy
);
	import adc_pkg::*;

	adc_host_s s_ff;
	adc_host_s nxt_s;
	logic      sdo_lvl;
	logic      half_end;

	// Data line comes from another domain
	adc_sync_edge #(.RST_VAL(1'b1)) u_sdo_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     (link.sdo_line),
		.lvl     (sdo_lvl),
		.rise    (),
		.fall    ()
	);

	// Half period rounded up keeps the clock at or below the bus limit
	assign half_end = (s_ff.div == 8'(SCK_HALF - 1));

	// ************************************************
	// Sequencer
	// ************************************************

	always_comb
	begin
		nxt_s       = s_ff;
		nxt_s.valid = 1'b0;
		case (s_ff.st)
			ADC_H_IDLE:
			begin
				nxt_s.sck  = CPOL;
				nxt_s.cs_n = 1'b1;
				if (start)
				begin
					nxt_s.cs_n  = 1'b0;
					nxt_s.armed = 1'b0;
					nxt_s.st    = ADC_H_WAIT;
				end
			end
			// Ready is a low after the line has been seen high
			ADC_H_WAIT:
			begin
				if (sdo_lvl)
					nxt_s.armed = 1'b1;
				if (s_ff.armed && !sdo_lvl)
				begin
					nxt_s.st   = ADC_H_CLK;
					nxt_s.sck  = 1'b1;
					nxt_s.ph   = 1'b1;
					nxt_s.div  = 8'h00;
					nxt_s.bits = '0;
				end
			end
			ADC_H_CLK:
			begin
				nxt_s.div = half_end ? 8'h00 : s_ff.div + 8'h01;
				if (half_end && s_ff.ph && s_ff.bits == 5'(`ADC_WORD_BITS))
				begin
					nxt_s.sck    = CPOL;
					nxt_s.result = s_ff.sh;
					nxt_s.valid  = 1'b1;
					nxt_s.armed  = 1'b0;
					if (continuous)
					begin
						nxt_s.st = ADC_H_WAIT;
					end
					else
					begin
						nxt_s.cs_n = 1'b1;
						nxt_s.st   = ADC_H_GAP;
					end
				end
				else if (half_end && s_ff.ph)
				begin
					nxt_s.sck = 1'b0;
					nxt_s.ph  = 1'b0;
				end
				else if (half_end)
				begin
					// Sample on the rise, first bit lands in the top
					nxt_s.sck  = 1'b1;
					nxt_s.ph   = 1'b1;
					nxt_s.sh   = {s_ff.sh[`ADC_WORD_BITS-2:0], sdo_lvl};
					nxt_s.bits = s_ff.bits + 5'h01;
				end
			end
			// Select stays high long enough before the next start
			ADC_H_GAP:
			begin
				nxt_s.div = s_ff.div + 8'h01;
				if (s_ff.div == 8'(GAP_CYC - 1))
				begin
					nxt_s.div = 8'h00;
					nxt_s.st  = ADC_H_IDLE;
				end
			end
			default: nxt_s.st = ADC_H_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_ff      <= '0;
			s_ff.st   <= ADC_H_IDLE;
			s_ff.cs_n <= 1'b1;
			s_ff.sck  <= CPOL;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	assign link.cs_n    = s_ff.cs_n;
	assign link.sck     = s_ff.sck;
	assign result       = s_ff.result;
	assign result_valid = s_ff.valid;
	assign busy         = (s_ff.st != ADC_H_IDLE);
endmodule

// *** testbench/adc_link_asserts.sv ***
// Concurrent checks on the signals of the converter link
`timescale 1ns/1ns
module adc_link_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Link signals
	input wire logic cs_n,
	input wire logic sck,
	input wire logic data_ready_out,
	input wire logic data_ready_oe,
	input wire logic sdo_line
);
	// ****************************************
	// Clocking and shared sequences
	// ****************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Select held long enough to cross the synchroniser and the output flop
	sequence sel_off_s;
		cs_n [*7];
	endsequence
	sequence sel_on_s;
		!cs_n [*7];
	endsequence
	// Clock high past the output lag, so nothing may still be moving
	sequence clk_high_s;
		sck [*8];
	endsequence

	// ****************************************
	// Converter end
	// ****************************************
	oe_release_a: assert property (sel_off_s |-> !data_ready_oe)
		else $error("data line driven while deselected");
	oe_drive_a: assert property (sel_on_s |-> data_ready_oe)
		else $error("data line not driven while selected");
	bit_hold_a: assert property ($fell(data_ready_out) |=> !data_ready_out [*4])
		else $error("low bit or ready did not stand");
	high_hold_a: assert property (clk_high_s |-> $stable(data_ready_out))
		else $error("data bit moved while clock high");

	// ****************************************
	// Host end, first link runs with clock idling low
	// ****************************************
	idle_clock_a: assert property (cs_n |-> !sck)
		else $error("clock away from idle level while deselected");
	clk_gated_a: assert property ($changed(sck) |-> !$past(cs_n))
		else $error("clock toggled outside select");
	clk_rate_a: assert property ($changed(sck) |=> $stable(sck) [*8])
		else $error("clock half period too short");
	cs_gap_a: assert property ($rose(cs_n) |=> cs_n [*8])
		else $error("select gap too short");

	// Main traffic seen at least once
	ready_seen_c: cover property ($fell(data_ready_out) && !cs_n && !sck);
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench: converter and host ends joined over the link
`timescale 1ns/1ns
`include "adc_params.svh"
module testbench;
	import adc_pkg::*;
	// Shortened counts; every expectation derives from these
	// A conversion must outlast one word readout, or a continuous run reloads mid-word
	localparam int CO    = 64;
	localparam int DV    = 10;
	localparam int SD    = 20;
	localparam int WARM  = (CO + `ADC_WARM_OSC) * DV;
	localparam int QUICK = CO * DV;

	logic               sys_clk    = 1'b0;
	logic               rst        = 1'b1;
	logic               start      = 1'b0;
	logic               continuous = 1'b0;
	logic signed [23:0] sample     = 24'sh0;
	adc_word_t          res0;
	adc_word_t          res1;
	logic               vld0;
	logic               busy0;
	logic               busy1;
	logic               done0;
	logic               shd0;
	logic               conv0;
	logic               dn2;
	int                 done2      = 0;
	int                 errors     = 0;
	int                 compares   = 0;
	int                 cycles     = 0;

	// ****************************************
	// Two links: clock idling low, and idling high
	// ****************************************
	adc_link_if lk ();
	adc_link_if lk1 ();

	adc_dev_end #(.CONV_OSC(CO), .OSC_DIV(DV), .SHDN_CYC(SD)) adc_dev_end_i (.sys_clk(sys_clk), .rst(rst),
		.link(lk), .sample_in(sample), .conv_done(done0), .in_shutdown(shd0), .converting(conv0));
	adc_host_end #(.CPOL(1'b0)) adc_host_end_i (.sys_clk(sys_clk), .rst(rst), .link(lk), .start(start),
		.continuous(continuous), .result(res0), .result_valid(vld0), .busy(busy0));
	adc_dev_end #(.CONV_OSC(CO), .OSC_DIV(DV), .SHDN_CYC(SD)) adc_dev_end1_i (.sys_clk(sys_clk), .rst(rst),
		.link(lk1), .sample_in(sample), .conv_done(), .in_shutdown(), .converting());
	adc_host_end #(.CPOL(1'b1)) adc_host_end1_i (.sys_clk(sys_clk), .rst(rst), .link(lk1), .start(start),
		.continuous(continuous), .result(res1), .result_valid(), .busy(busy1));

	// Third link: select tied low, clock held idle, converter runs on its own
	adc_link_if lk2 ();
	assign lk2.cs_n = 1'b0;
	assign lk2.sck  = 1'b0;
	adc_dev_end #(.CONV_OSC(CO), .OSC_DIV(DV), .SHDN_CYC(SD)) adc_dev_end2_i (.sys_clk(sys_clk), .rst(rst),
		.link(lk2), .sample_in(sample), .conv_done(dn2), .in_shutdown(), .converting());

	// Completions of the tied-low converter
	always @(posedge sys_clk)
	begin
		if (dn2 === 1'b1)
			done2 <= done2 + 1;
	end
	adc_link_asserts adc_link_asserts_i (.sys_clk(sys_clk), .rst(rst), .cs_n(lk.cs_n), .sck(lk.sck),
		.data_ready_out(lk.data_ready_out), .data_ready_oe(lk.data_ready_oe), .sdo_line(lk.sdo_line));

	always #5 sys_clk = ~sys_clk;

	// ****************************************
	// Compares and closing report
	// ****************************************
	task results();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk_w(input adc_word_t got, input adc_word_t exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task chk_b(input logic got, input logic exp);
		chk_w({23'h0, got}, {23'h0, exp});
	endtask

	// Cycle counts are judged against a window that covers the select synchroniser delay
	task chk_n(input int n, input int lo, input int hi);
		compares++;
		if (n < lo || n > hi)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, n, lo);
		end
	endtask

	// Expected word: two overrange flags, then the low 22 bits as they stand
	function automatic adc_word_t ex(input logic signed [23:0] v);
		return {v > 24'sh1fffff, v < -24'sh200000, v[21:0]};
	endfunction

	// One single conversion on both links; n counts select fall to completion
	task run1(input logic signed [23:0] v, input int lo, input int hi);
		int n;
		@(posedge sys_clk);
		sample <= v;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		while (lk.cs_n !== 1'b0) @(negedge sys_clk);
		n = 0;
		while (done0 !== 1'b1)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk_n(n, lo, hi);
		while (busy0 !== 1'b0 || busy1 !== 1'b0) @(negedge sys_clk);
		chk_w(res0, ex(v));
		chk_w(res1, ex(v));
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	// Boundaries of range and overrange, each from shutdown
	task t_single();
		adc_word_t tv [6] = '{24'h1fffff, 24'he00000, 24'h200005, 24'hdffffd, 24'h0a5c3e, 24'hffffff};
		foreach (tv[i])
		begin
			run1(tv[i], WARM, WARM + 8);
			repeat (SD + 10) @(negedge sys_clk);
			chk_b(shd0, 1'b1);
			chk_b(conv0, 1'b0);
			chk_b(lk.data_ready_oe, 1'b0);
			chk_b(lk.sdo_line, 1'b1);
		end
	endtask

	// Restart inside the idle window: no warm-up, fresh result
	task t_b2b();
		run1(24'h054321, WARM, WARM + 8);
		chk_b(shd0, 1'b0);
		run1(24'h3abcde, QUICK, QUICK + 8);
	endtask

	// Select held low: words keep coming without a new start
	task t_cont();
		@(posedge sys_clk);
		sample <= 24'sh1c0ffe;
		continuous <= 1'b1;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			while (vld0 !== 1'b1) @(negedge sys_clk);
			chk_w(res0, ex(24'sh1c0ffe));
			chk_b(lk.cs_n, k == 2);
			chk_b(conv0, 1'b1);
			@(posedge sys_clk);
			if (k == 1)
				continuous <= 1'b0;
		end
		while (busy0 !== 1'b0 || busy1 !== 1'b0) @(negedge sys_clk);
		chk_n(done2, 2, 1000);
	endtask

	// A hang ends the run as a failure; the tests need about 22000 cycles
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			errors++;
			results();
		end
	end

	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_single();
		t_b2b();
		t_cont();
		results();
	end
endmodule
